// [logic/igp_pkg.sv]
// igp_pkg: shared constants for the indexed gpio port block
// assumes: included by igp_port and igp_gpio; register word indices are
// scaled by four to form axi byte addresses
package igp_pkg;
    // register word indices, byte address is four times the index
    localparam logic [11:0] IDX_BASE = 12'hFD0;
    localparam logic [11:0] IDX_PA_INDEX = 12'hFD0;
    localparam logic [11:0] IDX_PA_ACCESS = 12'hFD1;
    localparam logic [11:0] IDX_PB_INDEX = 12'hFD4;
    localparam logic [11:0] IDX_PB_ACCESS = 12'hFD5;
    localparam logic [11:0] IDX_PC_INDEX = 12'hFD8;
    localparam logic [11:0] IDX_PC_ACCESS = 12'hFD9;
    localparam logic [11:0] IDX_PC_IN = 12'hFDA;
    localparam logic [11:0] IDX_PC_OUT = 12'hFDB;
    localparam logic [11:0] IDX_LAST = 12'hFDB;
    // register slot within a port group of four words
    localparam logic [1:0] REG_INDEX = 2'h0;
    localparam logic [1:0] REG_ACCESS = 2'h1;
    localparam logic [1:0] REG_IN = 2'h2;
    localparam logic [1:0] REG_OUT = 2'h3;
    // port group numbers
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam logic [1:0] PORT_C = 2'h2;
    localparam int PORT_CNT = 3;
    // sub-register selector codes held in the index register
    localparam logic [7:0] SEL_NONE = 8'h00;
    localparam logic [7:0] SEL_DIR = 8'h01;
    localparam logic [7:0] SEL_ALT = 8'h02;
    localparam logic [7:0] SEL_OD = 8'h03;
    localparam logic [7:0] SEL_HD = 8'h04;
    localparam logic [7:0] SEL_SMR = 8'h05;
    localparam logic [7:0] SEL_PU = 8'h06;
    // sub-register slots, selector minus SEL_DIR
    localparam int SUB_N = 6;
    localparam logic [2:0] SUB_DIR = 3'h0;
    localparam logic [2:0] SUB_ALT = 3'h1;
    localparam logic [2:0] SUB_OD = 3'h2;
    localparam logic [2:0] SUB_HD = 3'h3;
    localparam logic [2:0] SUB_SMR = 3'h4;
    localparam logic [2:0] SUB_PU = 3'h5;
    // reset values
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic RST_DIR_BIT = 1'b1;
    localparam logic RST_SUB_BIT = 1'b0;
    localparam logic RST_DATA_BIT = 1'b0;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int ADDR_MIN_W = 14;
endpackage

// [logic/igp_port.sv]
// igp_port: one gpio port, index and access registers, sub-registers,
// input and output data and the pin drivers
// assumes: pin inputs are asynchronous, strobes come from aclk logic
`timescale 1ns/1ps
module igp_port #(
    parameter int W = 8
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write strobes and data from the bus slave
    input wire logic idx_we,
    input wire logic ctl_we,
    input wire logic out_we,
    input wire logic [7:0] wdata,
    // readback
    output logic [7:0] idx_rd,
    output logic [7:0] ctl_rd,
    output logic [7:0] in_rd,
    output logic [7:0] out_rd,
    output logic [W-1:0] dir_q,
    output logic [W-1:0] af_q,
    output logic [W-1:0] od_q,
    // pins and alternate function
    input wire logic [W-1:0] pin_in,
    input wire logic [W-1:0] alt_out,
    input wire logic [W-1:0] alt_oe,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe_n,
    output logic [W-1:0] high_drive,
    output logic [W-1:0] pullup_en,
    output logic [W-1:0] stop_rec_en
);
    if (W < 1 || W > 8) begin : g_chk
        $error("igp_port: width must be 1 to 8");
    end

    logic [7:0] idx_r; // sub-register selector
    logic [W-1:0] sub_r [0:igp_pkg::SUB_N-1]; // configuration sub-registers
    logic [W-1:0] in_r; // sampled pin levels
    logic [W-1:0] out_r; // output data
    logic [W-1:0] sync1_r; // first synchroniser stage
    logic [W-1:0] sync2_r; // second stage, safe to read
    logic [W-1:0] pin_out_r;
    logic [W-1:0] pin_oe_n_r;
    logic sel_ok; // index names a real sub-register
    logic [2:0] sel; // slot of the selected sub-register
    logic [W-1:0] val; // level the pin would carry
    logic [W-1:0] drv; // pin would be driven

    assign sel_ok = idx_r >= igp_pkg::SEL_DIR && idx_r <= igp_pkg::SEL_PU;
    assign sel = 3'(idx_r - igp_pkg::SEL_DIR);

    // index register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx_r <= igp_pkg::RST_INDEX;
        end else if (ce && idx_we) begin
            idx_r <= wdata;
        end
    end

    // sub-registers; unmapped selectors swallow the write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < igp_pkg::SUB_N; i++) begin
                sub_r[i] <= {W{igp_pkg::RST_SUB_BIT}};
            end
            sub_r[igp_pkg::SUB_DIR] <= {W{igp_pkg::RST_DIR_BIT}};
        end else if (ce && ctl_we && sel_ok) begin
            sub_r[sel] <= wdata[W-1:0];
        end
    end

    // output data register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_r <= {W{igp_pkg::RST_DATA_BIT}};
        end else if (ce && out_we) begin
            out_r <= wdata[W-1:0];
        end
    end

    // two-stage synchroniser on the pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (ce) begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // only input pins refresh their bit; outputs keep the last sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_r <= {W{igp_pkg::RST_DATA_BIT}};
        end else if (ce) begin
            in_r <= (sync2_r & dir_q) | (in_r & ~dir_q);
        end
    end

    // alternate function overrides direction; open drain never drives 1
    assign val = (af_q & alt_out) | (~af_q & out_r);
    assign drv = (af_q & alt_oe) | (~af_q & ~dir_q);

    // registered pin drivers, released while in reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_r <= '0;
            pin_oe_n_r <= '1;
        end else if (ce) begin
            pin_out_r <= val;
            pin_oe_n_r <= ~(drv & ~(od_q & val));
        end
    end

    assign dir_q = sub_r[igp_pkg::SUB_DIR];
    assign af_q = sub_r[igp_pkg::SUB_ALT];
    assign od_q = sub_r[igp_pkg::SUB_OD];
    assign high_drive = sub_r[igp_pkg::SUB_HD];
    assign stop_rec_en = sub_r[igp_pkg::SUB_SMR];
    assign pullup_en = sub_r[igp_pkg::SUB_PU];
    assign pin_out = pin_out_r;
    assign pin_oe_n = pin_oe_n_r;
    assign idx_rd = idx_r;
    assign ctl_rd = sel_ok ? 8'(sub_r[sel]) : 8'h00;
    assign in_rd = 8'(in_r);
    assign out_rd = 8'(out_r);
endmodule

// [logic/igp_gpio.sv]
// igp_gpio: axi4-lite slave over three indexed gpio ports a, b, c
// assumes: one clock, synchronous active-low reset, pins asynchronous
`timescale 1ns/1ps
module igp_gpio #(
    parameter int ADDR_W = 14,
    parameter int PA_W = 8,
    parameter int PB_W = 8,
    parameter int PC_W = 6
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // port a pins
    input wire logic [PA_W-1:0] pa_pin_in,
    input wire logic [PA_W-1:0] pa_alt_out,
    input wire logic [PA_W-1:0] pa_alt_oe,
    output logic [PA_W-1:0] pa_pin_out,
    output logic [PA_W-1:0] pa_pin_oe_n,
    output logic [PA_W-1:0] pa_high_drive,
    output logic [PA_W-1:0] pa_pullup_en,
    output logic [PA_W-1:0] pa_stop_rec_en,
    // port b pins
    input wire logic [PB_W-1:0] pb_pin_in,
    input wire logic [PB_W-1:0] pb_alt_out,
    input wire logic [PB_W-1:0] pb_alt_oe,
    output logic [PB_W-1:0] pb_pin_out,
    output logic [PB_W-1:0] pb_pin_oe_n,
    output logic [PB_W-1:0] pb_high_drive,
    output logic [PB_W-1:0] pb_pullup_en,
    output logic [PB_W-1:0] pb_stop_rec_en,
    // port c pins
    input wire logic [PC_W-1:0] pc_pin_in,
    input wire logic [PC_W-1:0] pc_alt_out,
    input wire logic [PC_W-1:0] pc_alt_oe,
    output logic [PC_W-1:0] pc_pin_out,
    output logic [PC_W-1:0] pc_pin_oe_n,
    output logic [PC_W-1:0] pc_high_drive,
    output logic [PC_W-1:0] pc_pullup_en,
    output logic [PC_W-1:0] pc_stop_rec_en
);
    if (ADDR_W < igp_pkg::ADDR_MIN_W) begin : g_chk
        $error("igp_gpio: address too narrow for the register map");
    end

    // write channel state
    logic aw_held_r; // address captured, waiting for data
    logic [ADDR_W-1:0] aw_addr_r;
    logic w_held_r; // data captured, waiting for address
    logic [7:0] w_data_r; // only lane 0 carries register data
    logic w_lane_r; // lane 0 strobe was set
    logic bvalid_r;
    logic [1:0] bresp_r;
    // read channel state
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    // decode results
    logic wr_hit, rd_hit;
    logic [1:0] wr_port, wr_reg, rd_port, rd_reg;
    logic do_write; // both halves held, response slot free
    logic rd_take; // read address handshake
    logic [7:0] rd_mux;
    // per-port strobes and readback
    logic [igp_pkg::PORT_CNT-1:0] idx_we, ctl_we, out_we;
    logic [7:0] rd_idx [0:igp_pkg::PORT_CNT-1];
    logic [7:0] rd_ctl [0:igp_pkg::PORT_CNT-1];
    logic [7:0] rd_in [0:igp_pkg::PORT_CNT-1];
    logic [7:0] rd_out [0:igp_pkg::PORT_CNT-1];
    // port c state exposed for the checks below
    logic [PC_W-1:0] pc_dir, pc_af, pc_od;

    // word index to port and slot; anything outside the window misses
    function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        logic [ADDR_W-1:0] off;
        logic hit;
        w = a >> 2;
        off = w - ADDR_W'(igp_pkg::IDX_BASE);
        hit = w >= ADDR_W'(igp_pkg::IDX_BASE)
            && w <= ADDR_W'(igp_pkg::IDX_LAST);
        return {hit, off[3:2], off[1:0]};
    endfunction

    assign {wr_hit, wr_port, wr_reg} = decode(aw_addr_r);
    assign {rd_hit, rd_port, rd_reg} = decode(s_axi_araddr);

    // handshakes, all frozen while ce is low
    assign s_axi_awready = ce && !aw_held_r;
    assign s_axi_wready = ce && !w_held_r;
    assign s_axi_arready = ce && !rvalid_r;
    assign do_write = ce && aw_held_r && w_held_r && !bvalid_r;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    // write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
    end

    // write data capture, in either order against the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 8'h00;
            w_lane_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end
    end

    // write response; a miss is answered with slverr and no effect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= igp_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? igp_pkg::RESP_OKAY : igp_pkg::RESP_SLVERR;
        end else if (ce && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // per-port strobes; the input slot takes no write
    always_comb begin
        idx_we = '0;
        ctl_we = '0;
        out_we = '0;
        if (do_write && wr_hit && w_lane_r) begin
            case (wr_reg)
                igp_pkg::REG_INDEX: idx_we[wr_port] = 1'b1;
                igp_pkg::REG_ACCESS: ctl_we[wr_port] = 1'b1;
                igp_pkg::REG_OUT: out_we[wr_port] = 1'b1;
                default: ; // read-only input data
            endcase
        end
    end

    // read data mux
    always_comb begin
        case (rd_reg)
            igp_pkg::REG_INDEX: rd_mux = rd_idx[rd_port];
            igp_pkg::REG_ACCESS: rd_mux = rd_ctl[rd_port];
            igp_pkg::REG_IN: rd_mux = rd_in[rd_port];
            default: rd_mux = rd_out[rd_port];
        endcase
    end

    // read response, one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= igp_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_hit ? 32'(rd_mux) : 32'h0000_0000;
            rresp_r <= rd_hit ? igp_pkg::RESP_OKAY : igp_pkg::RESP_SLVERR;
        end else if (ce && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // port a
    igp_port #(.W(PA_W)) u_pa (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .idx_we(idx_we[igp_pkg::PORT_A]), .ctl_we(ctl_we[igp_pkg::PORT_A]),
        .out_we(out_we[igp_pkg::PORT_A]), .wdata(w_data_r),
        .idx_rd(rd_idx[igp_pkg::PORT_A]), .ctl_rd(rd_ctl[igp_pkg::PORT_A]),
        .in_rd(rd_in[igp_pkg::PORT_A]), .out_rd(rd_out[igp_pkg::PORT_A]),
        .dir_q(), .af_q(), .od_q(),
        .pin_in(pa_pin_in), .alt_out(pa_alt_out), .alt_oe(pa_alt_oe),
        .pin_out(pa_pin_out), .pin_oe_n(pa_pin_oe_n),
        .high_drive(pa_high_drive), .pullup_en(pa_pullup_en),
        .stop_rec_en(pa_stop_rec_en)
    );

    // port b
    igp_port #(.W(PB_W)) u_pb (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .idx_we(idx_we[igp_pkg::PORT_B]), .ctl_we(ctl_we[igp_pkg::PORT_B]),
        .out_we(out_we[igp_pkg::PORT_B]), .wdata(w_data_r),
        .idx_rd(rd_idx[igp_pkg::PORT_B]), .ctl_rd(rd_ctl[igp_pkg::PORT_B]),
        .in_rd(rd_in[igp_pkg::PORT_B]), .out_rd(rd_out[igp_pkg::PORT_B]),
        .dir_q(), .af_q(), .od_q(),
        .pin_in(pb_pin_in), .alt_out(pb_alt_out), .alt_oe(pb_alt_oe),
        .pin_out(pb_pin_out), .pin_oe_n(pb_pin_oe_n),
        .high_drive(pb_high_drive), .pullup_en(pb_pullup_en),
        .stop_rec_en(pb_stop_rec_en)
    );

    // port c, six pins
    igp_port #(.W(PC_W)) u_pc (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .idx_we(idx_we[igp_pkg::PORT_C]), .ctl_we(ctl_we[igp_pkg::PORT_C]),
        .out_we(out_we[igp_pkg::PORT_C]), .wdata(w_data_r),
        .idx_rd(rd_idx[igp_pkg::PORT_C]), .ctl_rd(rd_ctl[igp_pkg::PORT_C]),
        .in_rd(rd_in[igp_pkg::PORT_C]), .out_rd(rd_out[igp_pkg::PORT_C]),
        .dir_q(pc_dir), .af_q(pc_af), .od_q(pc_od),
        .pin_in(pc_pin_in), .alt_out(pc_alt_out), .alt_oe(pc_alt_oe),
        .pin_out(pc_pin_out), .pin_oe_n(pc_pin_oe_n),
        .high_drive(pc_high_drive), .pullup_en(pc_pullup_en),
        .stop_rec_en(pc_stop_rec_en)
    );

    // checks on port c
    logic [7:0] pc_idx; // current selector of port c
    logic [PC_W-1:0] pc_out; // current output data of port c
    logic pc_none; // selector names no sub-register
    assign pc_idx = rd_idx[igp_pkg::PORT_C];
    assign pc_out = rd_out[igp_pkg::PORT_C][PC_W-1:0];
    assign pc_none = pc_idx < igp_pkg::SEL_DIR || pc_idx > igp_pkg::SEL_PU;

    sequence s_pc_wr(logic [1:0] slot);
        do_write && wr_hit && w_lane_r && wr_port == igp_pkg::PORT_C
            && wr_reg == slot;
    endsequence

    sequence s_pc_rd(logic [1:0] slot);
        rd_take && rd_hit && rd_port == igp_pkg::PORT_C && rd_reg == slot;
    endsequence

    property p_map_dir;
        @(posedge aclk) disable iff (!aresetn)
        s_pc_wr(igp_pkg::REG_ACCESS) ##0 pc_idx == igp_pkg::SEL_DIR
            |=> pc_dir == $past(w_data_r[PC_W-1:0]);
    endproperty
    a_map_dir: assert property (p_map_dir)
        else $error("direction write through access lost");

    property p_map_alt;
        @(posedge aclk) disable iff (!aresetn)
        s_pc_wr(igp_pkg::REG_ACCESS) ##0 pc_idx == igp_pkg::SEL_ALT
            |=> pc_af == $past(w_data_r[PC_W-1:0]) && $stable(pc_dir);
    endproperty
    a_map_alt: assert property (p_map_alt)
        else $error("alternate write through access lost");

    property p_none_wr;
        @(posedge aclk) disable iff (!aresetn)
        s_pc_wr(igp_pkg::REG_ACCESS) ##0 pc_none
            |=> $stable(pc_dir) && $stable(pc_af) && $stable(pc_od);
    endproperty
    a_none_wr: assert property (p_none_wr)
        else $error("write with unmapped index changed a sub-register");

    property p_none_rd;
        @(posedge aclk) disable iff (!aresetn)
        s_pc_rd(igp_pkg::REG_ACCESS) ##0 pc_none
            |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000;
    endproperty
    a_none_rd: assert property (p_none_rd)
        else $error("read with unmapped index not zero");

    property p_out_drive;
        @(posedge aclk) disable iff (!aresetn)
        ce |=> ((~$past(pc_dir) & ~$past(pc_af) & ~$past(pc_od))
            & (pc_pin_oe_n | (pc_pin_out ^ $past(pc_out)))) == '0;
    endproperty
    a_out_drive: assert property (p_out_drive)
        else $error("output pin not driven from output data");

    property p_in_sample;
        @(posedge aclk) disable iff (!aresetn)
        ce [*3] ##1 1'b1 |-> ((rd_in[igp_pkg::PORT_C][PC_W-1:0]
            ^ $past(pc_pin_in, 3)) & $past(pc_dir)) == '0;
    endproperty
    a_in_sample: assert property (p_in_sample)
        else $error("input pin not sampled into input data");

    property p_in_hiz;
        @(posedge aclk) disable iff (!aresetn)
        ce |=> ($past(pc_dir) & ~$past(pc_af) & ~pc_pin_oe_n) == '0;
    endproperty
    a_in_hiz: assert property (p_in_hiz)
        else $error("input pin driver not released");

    property p_alt_wins;
        @(posedge aclk) disable iff (!aresetn)
        ce |=> ($past(pc_af) & ~$past(pc_od)
            & (pc_pin_oe_n ^ ~$past(pc_alt_oe))) == '0;
    endproperty
    a_alt_wins: assert property (p_alt_wins)
        else $error("alternate enable not in control of pin");

    property p_idx_store;
        @(posedge aclk) disable iff (!aresetn)
        s_pc_wr(igp_pkg::REG_INDEX) |=> pc_idx == $past(w_data_r);
    endproperty
    a_idx_store: assert property (p_idx_store)
        else $error("index register write lost");

    property p_b_hold;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !(ce && s_axi_bready)
            |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped before bready");

    property p_in_reserved;
        @(posedge aclk) disable iff (!aresetn)
        s_pc_rd(igp_pkg::REG_IN) |=> s_axi_rvalid
            && s_axi_rdata[31:PC_W] == '0 && s_axi_rresp == igp_pkg::RESP_OKAY;
    endproperty
    a_in_reserved: assert property (p_in_reserved)
        else $error("input data reserved bits not zero");

    property p_out_store;
        @(posedge aclk) disable iff (!aresetn)
        s_pc_wr(igp_pkg::REG_OUT) |=> pc_out == $past(w_data_r[PC_W-1:0]);
    endproperty
    a_out_store: assert property (p_out_store)
        else $error("output data write lost");
endmodule

// [tb/igp_pin_model.sv]
// igp_pin_model: outside circuitry on the port c pins
// assumes: released pins show whatever the outside world drives
`timescale 1ns/1ps
module igp_pin_model #(
    parameter int W = 6
) (
    // pin drive from the port
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe_n,
    // outside level on released pins
    input wire logic [W-1:0] ext,
    output logic [W-1:0] pin_in
);
    // driven pins read back, released pins follow the outside
    always_comb pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
endmodule

// [tb/igp_gpio_tb_top.sv]
// igp_gpio_tb_top: self-checking bench for the indexed gpio block
// assumes: 40 MHz aclk, bench is the axi4-lite master
`timescale 1ns/1ps
module igp_gpio_tb_top;
    logic aclk = 0, aresetn = 0, ce = 1;
    logic [13:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [7:0] pa_i = 0, pa_o = 0, pa_e = 0, pb_i = 0, pb_o = 0, pb_e = 0;
    logic [5:0] pc_i, pc_o = 0, pc_e = 0, pc_out, pc_oen, ext = 0;
    logic [5:0] pc_hd, pc_pu, pc_sr;
    logic [33:0] exp_q[$]; // expected {resp, data} per read
    logic [1:0] exp_b[$]; // expected response per write
    logic [7:0] v, dv;
    int failures = 0, n_tests = 0;
    always #12.5 aclk = ~aclk;
    igp_gpio dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pa_pin_in(pa_i), .pa_alt_out(pa_o), .pa_alt_oe(pa_e),
        .pa_pin_out(), .pa_pin_oe_n(), .pa_high_drive(), .pa_pullup_en(),
        .pa_stop_rec_en(), .pb_pin_in(pb_i), .pb_alt_out(pb_o),
        .pb_alt_oe(pb_e), .pb_pin_out(), .pb_pin_oe_n(), .pb_high_drive(),
        .pb_pullup_en(), .pb_stop_rec_en(), .pc_pin_in(pc_i),
        .pc_alt_out(pc_o), .pc_alt_oe(pc_e), .pc_pin_out(pc_out),
        .pc_pin_oe_n(pc_oen), .pc_high_drive(pc_hd), .pc_pullup_en(pc_pu),
        .pc_stop_rec_en(pc_sr));
    igp_pin_model pins_u (.pin_out(pc_out), .pin_oe_n(pc_oen), .ext(ext),
        .pin_in(pc_i));
    // one comparison, reads and pins alike
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [33:0] ok(input logic [7:0] d);
        return {igp_pkg::RESP_OKAY, 24'h0, d};
    endfunction
    // write response check
    task automatic cmp_b(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t bresp got=%h exp=%h", $time, got, exp);
        end
    endtask
    // axi write, called just after a rising edge
    task automatic wr(input logic [11:0] idx, input logic [7:0] d,
            input logic [1:0] eb = igp_pkg::RESP_OKAY);
        logic a, w, sa, sw, b;
        exp_b.push_back(eb);
        a = 1;
        w = 1;
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (a || w) begin
            @(negedge aclk);
            sa = awready;
            sw = wready;
            @(posedge aclk);
            if (a && sa) begin
                a = 0;
                awvalid <= 0;
            end
            if (w && sw) begin
                w = 0;
                wvalid <= 0;
            end
        end
        do begin
            @(negedge aclk);
            b = bvalid;
            @(posedge aclk);
        end while (!b);
        // bready stays high; every call sets it again and nothing ever lowers it
    endtask
    // axi read; the monitor below checks the answer
    task automatic rd(input logic [11:0] idx, input logic [33:0] e);
        logic s;
        exp_q.push_back(e);
        araddr <= {idx, 2'h0};
        arvalid <= 1;
        rready <= 1;
        do begin
            @(negedge aclk);
            s = arready;
            @(posedge aclk);
        end while (!s);
        arvalid <= 0;
        do begin
            @(negedge aclk);
            s = rvalid;
            @(posedge aclk);
        end while (!s);
    endtask
    // pre-edge values, so the handshake edge is seen exactly once
    always @(posedge aclk)
        if (rvalid === 1'b1 && rready && ce)
            cmp({rresp, rdata}, exp_q.pop_front());
    always @(posedge aclk)
        if (bvalid === 1'b1 && bready && ce)
            cmp_b(bresp, exp_b.pop_front());
    task automatic results;
        $display("n_tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #500_000;
        failures++;
        results;
    end
    initial begin
        void'($urandom(78));
        {pa_i, pa_o, pa_e} <= 24'($urandom);
        {pb_i, pb_o, pb_e} <= 24'($urandom);
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        rd(igp_pkg::IDX_PC_INDEX, ok(8'h00));
        rd(igp_pkg::IDX_PC_ACCESS, ok(8'h00));
        rd(igp_pkg::IDX_PA_ACCESS, ok(8'h00));
        rd(igp_pkg::IDX_PB_ACCESS, ok(8'h00));
        wr(igp_pkg::IDX_PA_INDEX, 8'h01);
        wr(igp_pkg::IDX_PA_ACCESS, 8'hA5);
        rd(igp_pkg::IDX_PA_ACCESS, ok(8'hA5));
        // every mapped selector: index first, then the sub-register
        for (int s = 1; s <= 6; s++) begin
            v = 8'($urandom) & 8'h3F;
            if (s == 1) dv = v;
            wr(igp_pkg::IDX_PC_INDEX, 8'(s));
            wr(igp_pkg::IDX_PC_ACCESS, v);
            rd(igp_pkg::IDX_PC_INDEX, ok(8'(s)));
            rd(igp_pkg::IDX_PC_ACCESS, ok(v));
            if (s == 4) cmp({28'h0, pc_hd}, {26'h0, v});
            if (s == 5) cmp({28'h0, pc_sr}, {26'h0, v});
            if (s == 6) cmp({28'h0, pc_pu}, {26'h0, v});
        end
        // unmapped selectors swallow writes and read zero
        wr(igp_pkg::IDX_PC_INDEX, 8'h07);
        wr(igp_pkg::IDX_PC_ACCESS, 8'h15);
        rd(igp_pkg::IDX_PC_ACCESS, ok(8'h00));
        wr(igp_pkg::IDX_PC_INDEX, 8'hFF);
        rd(igp_pkg::IDX_PC_ACCESS, ok(8'h00));
        wr(igp_pkg::IDX_PC_INDEX, 8'h01);
        rd(igp_pkg::IDX_PC_ACCESS, ok(dv));
        // clear alternate and open-drain, then all outputs
        for (int s = 3; s >= 1; s--) begin
            wr(igp_pkg::IDX_PC_INDEX, 8'(s));
            wr(igp_pkg::IDX_PC_ACCESS, 8'h00);
        end
        v = 8'($urandom) & 8'h3F;
        wr(igp_pkg::IDX_PC_OUT, v);
        wstrb <= 4'h0; // lane 0 off: answered, but must not land
        wr(igp_pkg::IDX_PC_OUT, ~v);
        wstrb <= 4'hF;
        rd(igp_pkg::IDX_PC_OUT, ok(v));
        repeat (2) @(posedge aclk);
        cmp({28'h0, pc_out}, {26'h0, v});
        cmp({28'h0, pc_oen}, 34'h0);
        // all inputs: driver released, pins sampled
        ext <= 6'($urandom);
        wr(igp_pkg::IDX_PC_ACCESS, 8'h3F);
        repeat (4) @(posedge aclk);
        cmp({28'h0, pc_oen}, 34'h3F);
        rd(igp_pkg::IDX_PC_IN, ok({2'h0, ext}));
        // enable low: pins move, the input register must stay frozen
        ce <= 0;
        ext <= ~ext;
        repeat (5) @(posedge aclk);
        ce <= 1;
        rd(igp_pkg::IDX_PC_IN, ok({2'h0, ~ext}));
        wr(igp_pkg::IDX_PC_IN, ~{2'h0, ext});
        rd(igp_pkg::IDX_PC_IN, ok({2'h0, ext}));
        // alternate function wins over direction
        pc_e <= 6'($urandom);
        pc_o <= 6'($urandom);
        wr(igp_pkg::IDX_PC_INDEX, 8'h02);
        wr(igp_pkg::IDX_PC_ACCESS, 8'h3F);
        repeat (2) @(posedge aclk);
        cmp({28'h0, pc_oen}, {28'h0, ~pc_e});
        cmp({28'h0, pc_out & pc_e}, {28'h0, pc_o & pc_e});
        wr(12'hFDC, 8'hFF, igp_pkg::RESP_SLVERR);
        rd(12'hFDC, {igp_pkg::RESP_SLVERR, 32'h0});
        repeat (2) @(posedge aclk);
        results;
    end
endmodule
